// ==== pkg/capc_pkg.sv ====
// constants, types and helpers shared by the command/address parity checker
`default_nettype none
package capc_pkg;
    // command frame: act_n, addr[16:0] (a16 row, a15 col, a14 we), bg[1:0], ba[1:0]
    localparam int FRAME_W = 22;
    localparam int FR_ACT = 21;
    localparam int FR_ADDR_LSB = 4;
    localparam int FR_BG_LSB = 2;
    localparam int FR_BA_LSB = 0;
    localparam int ADDR_W = 17;

    // clock and timing
    localparam int CLK_MHZ = 25;
    localparam int ALERT_PW_NS = 1600;
    localparam logic [7:0] ALERT_PW_CYC = 8'((ALERT_PW_NS * CLK_MHZ + 999) / 1000);

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LOG_ADDR = 8'h04;
    localparam logic [7:0] REG_LOG_CMD = 8'h08;
    localparam logic [7:0] REG_LAT_CFG = 8'h0c;
    localparam logic [7:0] REG_LAT_STAT = 8'h10;

    // mode_register_five control fields
    localparam int CTRL_PAR_LAT_LSB = 0;
    localparam int CTRL_STAT_BIT = 4;
    localparam int CTRL_PERSIST_BIT = 9;
    localparam logic [2:0] CTRL_PAR_LAT_RST = 3'h0;

    // latency config / status fields
    localparam int LAT_W = 5;
    localparam int LAT_AL_LSB = 0;
    localparam int LAT_CL_LSB = 8;
    localparam int LAT_CWL_LSB = 16;
    localparam int STAT_RL_LSB = 0;
    localparam int STAT_WL_LSB = 16;
    localparam logic [14:0] LAT_CFG_RST = 15'h0000;

    // log command register fields
    localparam int LOG_BA_LSB = 0;
    localparam int LOG_BG_LSB = 2;
    localparam int LOG_ACT_BIT = 4;
    localparam int LOG_PAR_BIT = 5;

    // parity_latency codes
    localparam logic [2:0] PAR_LAT_OFF = 3'h0;
    localparam logic [2:0] PAR_LAT_4 = 3'h1;
    localparam logic [2:0] PAR_LAT_5 = 3'h2;
    localparam logic [2:0] PAR_LAT_6 = 3'h3;
    localparam logic [2:0] PAR_LAT_8 = 3'h4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        CAPC_IDLE = 1'h0,
        CAPC_ALERT = 1'h1
    } capc_state_t;

    // codes above the reserved_code one act as disabled
    function automatic logic [3:0] par_lat_clocks(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h0;
        unique case (code)
            PAR_LAT_4: n = 4'h4;
            PAR_LAT_5: n = 4'h5;
            PAR_LAT_6: n = 4'h6;
            PAR_LAT_8: n = 4'h8;
            default: n = 4'h0;
        endcase
        return n;
    endfunction
endpackage
`default_nettype wire

// ==== pkg/capc_cmd_if.sv ====
// command frame carrier between the checker and its latency line
`timescale 1ns/1ps
`default_nettype none
interface capc_cmd_if;
    logic valid;
    logic [capc_pkg::FRAME_W-1:0] frame;
    modport src (output valid, output frame);
    modport dst (input valid, input frame);
endinterface
`default_nettype wire

// ==== verilog/capc_delay.sv ====
// parity latency line: delays each accepted frame by the programmed clocks, or by one clock when latency is 0
`timescale 1ns/1ps
`default_nettype none
module capc_delay (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic [3:0] par_lat_clk_in,
    capc_cmd_if.dst in_port,
    capc_cmd_if.src out_port
);
    logic [capc_pkg::FRAME_W:0] line_q [0:6];
    logic [capc_pkg::FRAME_W:0] line_d [0:6];
    logic [capc_pkg::FRAME_W:0] out_q;
    logic [capc_pkg::FRAME_W:0] out_d;

    always_comb begin
        line_d[0] = {in_port.valid, in_port.frame};
        for (int i = 1; i < 7; i++) begin
            line_d[i] = line_q[i-1];
        end
        // output flop is the last stage, so tap sits two short of the latency
        if (par_lat_clk_in == 4'h0) begin
            out_d = line_d[0];
        end else begin
            out_d = line_q[3'(par_lat_clk_in - 4'h2)];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 7; i++) begin
                line_q[i] <= '0;
            end
            out_q <= '0;
        end else if (clk_en_in) begin
            line_q <= line_d;
            out_q <= out_d;
        end
    end

    assign out_port.valid = out_q[capc_pkg::FRAME_W];
    assign out_port.frame = out_q[capc_pkg::FRAME_W-1:0];
endmodule
`default_nettype wire

// ==== verilog/capc_checker.sv ====
// command/address parity checker with error response and axi4-lite registers
//
// Contract
// - parity latency codes 0,4,5,6,8 clocks
// - every command delayed by parity latency; with latency 0 the code still delays it by one clock
// - read/write latency include parity latency
// - status bit; non-persistent suspends checking until cleared
// - persistent mode resumes checking after alert
// - errored self-refresh entry becomes power-down
// - even parity over frame plus bit
// - parity covers act, row/col/we, address, banks
// - errored command ignored, logged, alert asserted
`timescale 1ns/1ps
`default_nettype none
module capc_checker (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic cs_n_in,
    input wire logic act_n_in,
    input wire logic [16:0] addr_in,
    input wire logic [1:0] bg_in,
    input wire logic [1:0] ba_in,
    input wire logic par_in,
    input wire logic cke_in,
    output logic exec_valid_out,
    output logic [21:0] exec_frame_out,
    output logic prech_all_out,
    output logic pd_entry_out,
    output logic alert_n_out,
    input wire logic [7:0] axi_awaddr_in,
    input wire logic axi_awvalid_in,
    output logic axi_awready_out,
    input wire logic [31:0] axi_wdata_in,
    input wire logic [3:0] axi_wstrb_in,
    input wire logic axi_wvalid_in,
    output logic axi_wready_out,
    output logic [1:0] axi_bresp_out,
    output logic axi_bvalid_out,
    input wire logic axi_bready_in,
    input wire logic [7:0] axi_araddr_in,
    input wire logic axi_arvalid_in,
    output logic axi_arready_out,
    output logic [31:0] axi_rdata_out,
    output logic [1:0] axi_rresp_out,
    output logic axi_rvalid_out,
    input wire logic axi_rready_in
);
    capc_cmd_if in_if ();
    capc_cmd_if out_if ();

    capc_pkg::capc_state_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic alert_n_q, alert_n_d, prech_q, prech_d, pd_q, pd_d;
    logic stat_q, stat_d, persist_q, persist_d;
    logic [2:0] par_lat_code_q, par_lat_code_d;
    logic [22:0] log_q, log_d;
    logic [14:0] lat_cfg_q, lat_cfg_d;
    logic [6:0] rl_q, rl_d, wl_q, wl_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d, rd_word;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [21:0] frame;
    logic [3:0] par_lat_clk;
    logic par_bad, chk_on, err_det, take, is_sre, wr_fire, rd_fire, ctrl_wr;

    // covered inputs only; cke, odt and cs stay outside
    assign frame = {act_n_in, addr_in, bg_in, ba_in};
    // even parity, an odd count of ones is an error
    assign par_bad = ^{frame, par_in};
    assign par_lat_clk = capc_pkg::par_lat_clocks(par_lat_code_q);
    // checking suspended while status set unless persistent
    assign chk_on = (par_lat_clk != 4'h0) && (!stat_q || persist_q) &&
        (state_q == capc_pkg::CAPC_IDLE);
    assign err_det = clk_en_in && !cs_n_in && chk_on && par_bad;
    assign is_sre = act_n_in && !addr_in[16] && !addr_in[15] && addr_in[14] && !cke_in;
    // errored frame and anything during the alert window is dropped
    assign take = clk_en_in && !cs_n_in && !err_det && (state_q == capc_pkg::CAPC_IDLE);

    assign in_if.valid = take;
    assign in_if.frame = frame;

    // every accepted command passes the latency line
    capc_delay u_delay (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .par_lat_clk_in(par_lat_clk),
        .in_port(in_if.dst),
        .out_port(out_if.src)
    );

    assign exec_valid_out = out_if.valid;
    assign exec_frame_out = out_if.frame;

    // error response sequence
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        prech_d = 1'b0;
        pd_d = 1'b0;
        unique case (state_q)
            capc_pkg::CAPC_IDLE: begin
                if (err_det) begin
                    state_d = capc_pkg::CAPC_ALERT;
                    cnt_d = capc_pkg::ALERT_PW_CYC;
                    // errored self-refresh entry falls back to power-down
                    pd_d = is_sre;
                end
            end
            capc_pkg::CAPC_ALERT: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    state_d = capc_pkg::CAPC_IDLE;
                    // banks closed by the end of the pulse; checking back then only in persistent mode
                    prech_d = 1'b1;
                end
            end
        endcase
        // alert held low for the whole window
        alert_n_d = (state_d == capc_pkg::CAPC_IDLE);
    end

    // register bus and register contents
    assign axi_awready_out = clk_en_in && !aw_have_q;
    assign axi_wready_out = clk_en_in && !w_have_q;
    assign axi_arready_out = clk_en_in && !rvalid_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign rd_fire = axi_arvalid_in && axi_arready_out;
    assign ctrl_wr = wr_fire && (aw_addr_q == capc_pkg::REG_CTRL);

    always_comb begin
        rd_word = 32'h0;
        unique case (axi_araddr_in)
            capc_pkg::REG_CTRL: begin
                rd_word[capc_pkg::CTRL_PAR_LAT_LSB +: 3] = par_lat_code_q;
                rd_word[capc_pkg::CTRL_STAT_BIT] = stat_q;
                rd_word[capc_pkg::CTRL_PERSIST_BIT] = persist_q;
            end
            capc_pkg::REG_LOG_ADDR: rd_word[capc_pkg::ADDR_W-1:0] = log_q[20:4];
            capc_pkg::REG_LOG_CMD: begin
                rd_word[capc_pkg::LOG_BA_LSB +: 2] = log_q[1:0];
                rd_word[capc_pkg::LOG_BG_LSB +: 2] = log_q[3:2];
                rd_word[capc_pkg::LOG_ACT_BIT] = log_q[21];
                rd_word[capc_pkg::LOG_PAR_BIT] = log_q[22];
            end
            capc_pkg::REG_LAT_CFG: begin
                rd_word[capc_pkg::LAT_AL_LSB +: 5] = lat_cfg_q[4:0];
                rd_word[capc_pkg::LAT_CL_LSB +: 5] = lat_cfg_q[9:5];
                rd_word[capc_pkg::LAT_CWL_LSB +: 5] = lat_cfg_q[14:10];
            end
            capc_pkg::REG_LAT_STAT: begin
                rd_word[capc_pkg::STAT_RL_LSB +: 7] = rl_q;
                rd_word[capc_pkg::STAT_WL_LSB +: 7] = wl_q;
            end
            default: rd_word = 32'h0;
        endcase
    end

    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        par_lat_code_d = par_lat_code_q;
        persist_d = persist_q;
        lat_cfg_d = lat_cfg_q;
        if (axi_awvalid_in && axi_awready_out) begin
            aw_have_d = 1'b1;
            aw_addr_d = axi_awaddr_in;
        end
        if (axi_wvalid_in && axi_wready_out) begin
            w_have_d = 1'b1;
            w_data_d = axi_wdata_in;
            w_strb_d = axi_wstrb_in;
        end
        if (bvalid_q && axi_bready_in) begin
            bvalid_d = 1'b0;
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = capc_pkg::RESP_OKAY;
            unique case (aw_addr_q)
                capc_pkg::REG_CTRL: begin
                    if (w_strb_q[0]) begin
                        par_lat_code_d = w_data_q[capc_pkg::CTRL_PAR_LAT_LSB +: 3];
                    end
                    if (w_strb_q[1]) begin
                        persist_d = w_data_q[capc_pkg::CTRL_PERSIST_BIT];
                    end
                end
                capc_pkg::REG_LAT_CFG: begin
                    if (w_strb_q[0]) begin
                        lat_cfg_d[4:0] = w_data_q[capc_pkg::LAT_AL_LSB +: 5];
                    end
                    if (w_strb_q[1]) begin
                        lat_cfg_d[9:5] = w_data_q[capc_pkg::LAT_CL_LSB +: 5];
                    end
                    if (w_strb_q[2]) begin
                        lat_cfg_d[14:10] = w_data_q[capc_pkg::LAT_CWL_LSB +: 5];
                    end
                end
                capc_pkg::REG_LOG_ADDR, capc_pkg::REG_LOG_CMD, capc_pkg::REG_LAT_STAT: begin
                    bresp_d = capc_pkg::RESP_OKAY;
                end
                default: bresp_d = capc_pkg::RESP_SLVERR;
            endcase
        end
        if (rvalid_q && axi_rready_in) begin
            rvalid_d = 1'b0;
        end
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rdata_d = rd_word;
            rresp_d = (axi_araddr_in > capc_pkg::REG_LAT_STAT || axi_araddr_in[1:0] != 2'h0) ?
                capc_pkg::RESP_SLVERR : capc_pkg::RESP_OKAY;
        end
        // software may only clear the status; a new error wins
        stat_d = stat_q;
        if (ctrl_wr && w_strb_q[0] && !w_data_q[capc_pkg::CTRL_STAT_BIT]) begin
            stat_d = 1'b0;
        end
        if (err_det) begin
            stat_d = 1'b1;
        end
        // log the failing frame with its parity bit
        log_d = err_det ? {par_in, frame} : log_q;
        // read and write latency carry the parity latency
        rl_d = 7'(lat_cfg_q[4:0]) + 7'(lat_cfg_q[9:5]) + 7'(par_lat_clk);
        wl_d = 7'(lat_cfg_q[4:0]) + 7'(lat_cfg_q[14:10]) + 7'(par_lat_clk);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= capc_pkg::CAPC_IDLE;
            cnt_q <= 8'h00;
            alert_n_q <= 1'b1;
            prech_q <= 1'b0;
            pd_q <= 1'b0;
            stat_q <= 1'b0;
            persist_q <= 1'b0;
            par_lat_code_q <= capc_pkg::CTRL_PAR_LAT_RST;
            log_q <= 23'h000000;
            lat_cfg_q <= capc_pkg::LAT_CFG_RST;
            rl_q <= 7'h00;
            wl_q <= 7'h00;
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_have_q <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'h0;
        end else if (clk_en_in) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            alert_n_q <= alert_n_d;
            prech_q <= prech_d;
            pd_q <= pd_d;
            stat_q <= stat_d;
            persist_q <= persist_d;
            par_lat_code_q <= par_lat_code_d;
            log_q <= log_d;
            lat_cfg_q <= lat_cfg_d;
            rl_q <= rl_d;
            wl_q <= wl_d;
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q <= w_have_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign alert_n_out = alert_n_q;
    assign prech_all_out = prech_q;
    assign pd_entry_out = pd_q;
    assign axi_bvalid_out = bvalid_q;
    assign axi_bresp_out = bresp_q;
    assign axi_rvalid_out = rvalid_q;
    assign axi_rdata_out = rdata_q;
    assign axi_rresp_out = rresp_q;

    // checks on the error response and latency
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    logic [7:0] low_len_q;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_len_q <= 8'h00;
        end else if (clk_en_in) begin
            low_len_q <= alert_n_out ? 8'h00 : low_len_q + 8'h01;
        end
    end

    sequence s_take_lat4;
        take && par_lat_clk == 4'h4 ##1 (clk_en_in && par_lat_clk == 4'h4) [*3];
    endsequence

    a_alert_on_err: assert property (err_det |=> !alert_n_out)
        else $error("alert not asserted after parity error");
    a_alert_width: assert property ($rose(alert_n_out) |-> low_len_q == capc_pkg::ALERT_PW_CYC)
        else $error("alert pulse width wrong");
    a_status_set: assert property (err_det |=> stat_q)
        else $error("status bit not set on error");
    a_check_suspend: assert property (clk_en_in && stat_q && !persist_q && alert_n_out |=>
        alert_n_out)
        else $error("checking active while status set");
    a_prech_at_end: assert property ($rose(alert_n_out) |-> prech_all_out)
        else $error("no precharge-all at alert release");
    a_sre_to_pd: assert property (err_det && is_sre |=> pd_entry_out)
        else $error("errored self-refresh entry not turned into power-down");
    a_lat_delay: assert property (s_take_lat4 |=> exec_valid_out)
        else $error("command not released after four clocks");
    a_rl_sum: assert property (clk_en_in && $past(clk_en_in) |->
        rl_q == 7'($past(lat_cfg_q[4:0])) + 7'($past(lat_cfg_q[9:5])) + 7'($past(par_lat_clk)))
        else $error("read latency sum wrong");
    a_log_frame: assert property (err_det |=> log_q == {$past(par_in), $past(frame)})
        else $error("error log does not hold failing frame");
    a_even_parity: assert property (clk_en_in && !cs_n_in && chk_on |->
        err_det == ^{act_n_in, addr_in, bg_in, ba_in, par_in})
        else $error("parity verdict differs from even parity over the pins");
endmodule
`default_nettype wire

// ==== verification/capc_ctrl_model.sv ====
// behavioural memory-controller model driving the command/address pins
`timescale 1ns/1ps
`default_nettype none
module capc_ctrl_model (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic req_in,
    input wire logic [21:0] frame_in,
    input wire logic bad_in,
    input wire logic sre_in,
    output logic cs_n_out,
    output logic [21:0] pins_out,
    output logic par_out,
    output logic cke_out
);
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_n_out <= 1'b1;
            pins_out <= 22'h0;
            par_out <= 1'b0;
            cke_out <= 1'b1;
        end else if (req_in) begin
            cs_n_out <= 1'b0;
            // frame carries act, strobes, address, banks
            pins_out <= frame_in;
            // even parity, broken only on request
            par_out <= (^frame_in) ^ bad_in;
            cke_out <= ~sre_in;
        end else begin
            // deselect only; released lines do not hold
            cs_n_out <= 1'b1;
            pins_out <= ~pins_out;
            par_out <= ~par_out;
            cke_out <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== verification/ca_parity_checker_tb.sv ====
// self-checking bench for the command/address parity checker
`timescale 1ns/1ps
`default_nettype none
module ca_parity_checker_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic [21:0] fr = 22'h0;
    logic bad = 1'b0;
    logic sre = 1'b0;
    logic cs_n, par, cke, exec_v, prech, pd, alert_n;
    logic [21:0] pins, exec_f;
    logic [7:0] awaddr = 8'h0;
    logic [7:0] araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
    int lats[6] = '{1, 4, 5, 6, 8, 1};
    logic [21:0] f;

    // clock never stops, even around self-refresh entry
    always #20 clk = ~clk;

    capc_ctrl_model ctrl (.sys_clk_in(clk), .rst_n_in(rst_n), .req_in(req), .frame_in(fr),
        .bad_in(bad), .sre_in(sre), .cs_n_out(cs_n), .pins_out(pins), .par_out(par),
        .cke_out(cke));

    capc_checker dut (.sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1), .cs_n_in(cs_n),
        .act_n_in(pins[21]), .addr_in(pins[20:4]), .bg_in(pins[3:2]), .ba_in(pins[1:0]),
        .par_in(par), .cke_in(cke), .exec_valid_out(exec_v), .exec_frame_out(exec_f),
        .prech_all_out(prech), .pd_entry_out(pd), .alert_n_out(alert_n),
        .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid), .axi_awready_out(awready),
        .axi_wdata_in(wdata), .axi_wstrb_in(wstrb), .axi_wvalid_in(wvalid),
        .axi_wready_out(wready), .axi_bresp_out(bresp), .axi_bvalid_out(bvalid),
        .axi_bready_in(bready), .axi_araddr_in(araddr), .axi_arvalid_in(arvalid),
        .axi_arready_out(arready), .axi_rdata_out(rdata), .axi_rresp_out(rresp),
        .axi_rvalid_out(rvalid), .axi_rready_in(rready));

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // generous ceiling: the whole sequence needs about 2000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            fails++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        logic [1:0] r;
        done = 1'b0;
        r = 2'h3;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
            input logic [1:0] er);
        logic done;
        logic [1:0] r;
        logic [31:0] d;
        done = 1'b0;
        r = 2'h3;
        d = 32'h0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                r = rresp;
                d = rdata;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        chk("rresp", {30'h0, er}, {30'h0, r});
        if (er == capc_pkg::RESP_OKAY) chk("rdata", e, d & m);
    endtask

    // lone frame, deselects around alert
    // one frame, then 50 cycles of deselects while the outputs are watched
    task automatic issue(input logic [21:0] fi, input logic b, input logic s, input int lat,
            input logic err);
        int ex_n, al_c, pr_n, pd_n;
        logic [21:0] ef;
        ex_n = 0;
        al_c = 0;
        pr_n = 0;
        pd_n = 0;
        ef = 22'h0;
        @(posedge clk);
        fr <= fi;
        bad <= b;
        sre <= s;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        for (int n = 1; n <= 50; n++) begin
            @(posedge clk);
            if (exec_v === 1'b1 && ex_n == 0) begin
                ex_n = n;
                ef = exec_f;
            end
            if (alert_n === 1'b0) al_c++;
            if (prech === 1'b1 && pr_n == 0) pr_n = n;
            if (pd === 1'b1 && pd_n == 0) pd_n = n;
        end
        chk("exec_cycle", err ? 32'h0 : 32'(lat), 32'(ex_n));
        if (!err) chk("exec_frame", {10'h0, fi}, {10'h0, ef});
        chk("alert_len", err ? 32'(capc_pkg::ALERT_PW_CYC) : 32'd0, 32'(al_c));
        chk("prech_cycle", err ? 32'(capc_pkg::ALERT_PW_CYC) + 32'd1 : 32'd0, 32'(pr_n));
        chk("pd_cycle", (err && s) ? 32'd1 : 32'd0, 32'(pd_n));
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("alert_idle", 32'h1, {31'h0, alert_n});
        rreg(capc_pkg::REG_CTRL, 32'hffffffff, 32'h0, capc_pkg::RESP_OKAY);
        rreg(8'h14, 32'h0, 32'h0, capc_pkg::RESP_SLVERR);
        wreg(8'h20, 32'h0, capc_pkg::RESP_SLVERR);
        wreg(capc_pkg::REG_LAT_STAT, 32'hffffffff, capc_pkg::RESP_OKAY);
        rreg(capc_pkg::REG_LAT_STAT, 32'hffffffff, 32'h0, capc_pkg::RESP_OKAY);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            wreg(capc_pkg::REG_CTRL, 32'h0, capc_pkg::RESP_OKAY);
            wreg(capc_pkg::REG_CTRL, {29'h0, codes[i]}, capc_pkg::RESP_OKAY);
            repeat (8) @(posedge clk);
            issue(22'h1234c5 ^ 22'(i), 1'b0, 1'b0, lats[i], 1'b0);
        end
        $display("test latency codes done");
        wreg(capc_pkg::REG_CTRL, 32'h0, capc_pkg::RESP_OKAY);
        wreg(capc_pkg::REG_CTRL, 32'h2, capc_pkg::RESP_OKAY);
        wreg(capc_pkg::REG_LAT_CFG, 32'h000c1103, capc_pkg::RESP_OKAY);
        rreg(capc_pkg::REG_LAT_STAT, 32'h007f007f, 32'h00140019, capc_pkg::RESP_OKAY);
        wreg(capc_pkg::REG_CTRL, 32'h0, capc_pkg::RESP_OKAY);
        rreg(capc_pkg::REG_LAT_STAT, 32'h007f007f, 32'h000f0014, capc_pkg::RESP_OKAY);
        wreg(capc_pkg::REG_CTRL, 32'h1, capc_pkg::RESP_OKAY);
        $display("test read write latency done");
        // a single set bit per frame exposes any input left out of the sum
        for (int i = 0; i < 22; i++) begin
            issue(22'(1) << i, 1'b0, 1'b0, 4, 1'b0);
        end
        $display("test parity coverage done");
        f = 22'h2c3a17;
        issue(f, 1'b1, 1'b0, 0, 1'b1);
        rreg(capc_pkg::REG_CTRL, 32'h217, 32'h11, capc_pkg::RESP_OKAY);
        rreg(capc_pkg::REG_LOG_ADDR, 32'h1ffff, {15'h0, f[20:4]}, capc_pkg::RESP_OKAY);
        rreg(capc_pkg::REG_LOG_CMD, 32'h3f, {26'h0, ~^f, f[21], f[3:0]}, capc_pkg::RESP_OKAY);
        issue(f, 1'b1, 1'b0, 4, 1'b0);
        wreg(capc_pkg::REG_CTRL, 32'h1, capc_pkg::RESP_OKAY);
        wreg(capc_pkg::REG_CTRL, 32'h11, capc_pkg::RESP_OKAY);
        rreg(capc_pkg::REG_CTRL, 32'h217, 32'h1, capc_pkg::RESP_OKAY);
        issue(f, 1'b1, 1'b0, 0, 1'b1);
        $display("test error response done");
        wreg(capc_pkg::REG_CTRL, 32'h201, capc_pkg::RESP_OKAY);
        issue(f ^ 22'h1, 1'b1, 1'b0, 0, 1'b1);
        rreg(capc_pkg::REG_CTRL, 32'h217, 32'h211, capc_pkg::RESP_OKAY);
        issue(f, 1'b1, 1'b0, 0, 1'b1);
        $display("test persistent mode done");
        wreg(capc_pkg::REG_CTRL, 32'h1, capc_pkg::RESP_OKAY);
        issue(22'h240000, 1'b0, 1'b1, 4, 1'b0);
        issue(22'h240000, 1'b1, 1'b1, 0, 1'b1);
        $display("test self refresh entry done");
        results();
    end
endmodule
`default_nettype wire
